/* File: rxf_pkg.sv */
// Constants, types and field layouts for the receive frame filter.
// Assumes one core clock; a low-frequency tick enable marks sampling edges.
package rxf_pkg;
    localparam int DATA_W = 9;
    localparam int DIV_W = 15;
    localparam int FRAC_W = 8;
    localparam int POS_W = DIV_W + 5;
    localparam int BIT_W = 4;
    localparam int BUF_DEPTH_DEF = 2;
    localparam logic [POS_W-1:0] HALF_SHIFT = 20'h00001;

    // Frame format, address match, hold release and loopback configuration
    typedef struct packed {
        logic nine_bits;
        logic parity_en;
        logic parity_odd;
        logic two_stop;
        logic multidrop_enable;
        logic addr_bit_value;
        logic start_frame_unhold;
        logic internal_loop;
    } rx_cfg_t;

    // Frame as stored in the buffer
    typedef struct packed {
        logic parity_fault;
        logic frame_fault;
        logic [DATA_W-1:0] data;
    } rx_word_t;

    // One-cycle event pulses
    typedef struct packed {
        logic parity_fault;
        logic frame_fault;
        logic start_match_flag;
        logic signal_match_flag;
        logic addr_frame_flag;
        logic rx_overrun_flag;
    } rx_evt_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RECV
    } rx_state_t;
endpackage

/* File: rx_frame_filter.sv */
// Receive frame recognition: sampling, error checks, hold and matching.
// Assumes i_lf_tick pulses once per 32.768 kHz edge; pins are asynchronous.
`timescale 1ns/1ps
module rx_frame_filter #(
    parameter int BUF_DEPTH = rxf_pkg::BUF_DEPTH_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_lf_tick,
    input wire logic i_rx_pin,
    input wire logic i_tx_pin,
    input wire logic i_rx_enable,
    input wire rxf_pkg::rx_cfg_t i_cfg,
    input wire logic [rxf_pkg::DIV_W-1:0] i_baud_divisor,
    input wire logic [rxf_pkg::DATA_W-1:0] i_start_match_pattern,
    input wire logic [rxf_pkg::DATA_W-1:0] i_signal_match_pattern,
    input wire logic i_hold_set_cmd,
    input wire logic i_hold_clear_cmd,
    input wire logic i_buf_pop,
    output logic o_receive_hold_flag,
    output logic o_rx_valid_flag,
    output rxf_pkg::rx_word_t o_rx_word,
    output rxf_pkg::rx_evt_t o_evt,
    output logic o_rx_on_status
);
    import rxf_pkg::*;

    localparam int CNT_W = $clog2(BUF_DEPTH + 1);
    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (BUF_DEPTH < 1 || BUF_DEPTH > 16)
    begin : g_bad_depth
        $error("BUF_DEPTH must be 1 to 16");
    end

    // ------------------------------------------------------------
    // All state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] rx_sync;
        logic [1:0] tx_sync;
        logic line_prev;
        rx_state_t state;
        logic [POS_W-1:0] cyc;
        logic [POS_W-1:0] target;
        logic [BIT_W-1:0] bit_idx;
        logic [DATA_W-1:0] shreg;
        logic par_acc;
        logic stop_bad;
        logic pend_valid;
        rx_word_t pend;
        logic [CNT_W-1:0] count;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W-1:0] wr_ptr;
        logic hold;
        logic valid;
        rx_word_t head;
        rx_evt_t evt;
        logic on;
    } st_t;

    st_t st_ff;
    st_t nxt_st;
    rx_word_t mem_ff [BUF_DEPTH];

    // Next pointer with wrap
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(BUF_DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
    endfunction

    // Pattern compare, low eight bits only for eight-bit frames
    function automatic logic pat_eq(input logic [DATA_W-1:0] a,
                                    input logic [DATA_W-1:0] b,
                                    input logic nine);
        pat_eq = nine ? (a == b) : (a[DATA_W-2:0] == b[DATA_W-2:0]);
    endfunction

    // Sample cycle: floor(n*(1+d/256)+d/512), worked in 1/512 units
    function automatic logic [POS_W-1:0] samp_pos(input logic [BIT_W-1:0] n,
                                                  input logic [DIV_W-1:0] d);
        logic [POS_W-1:0] per;
        logic [POS_W-1:0] pos;
        per = POS_W'(d) + (POS_W'(1) << FRAC_W);
        pos = POS_W'((POS_W'(n) * per << 1) + POS_W'(d));
        samp_pos = pos >> (FRAC_W + 1);
    endfunction

    // Combinational values used by the next-state logic
    logic line_in;
    logic [BIT_W-1:0] last_idx;
    logic [BIT_W-1:0] data_end;
    logic buf_full;
    logic push;
    rx_word_t push_word;

    always_comb
    begin
        line_in = i_cfg.internal_loop ? st_ff.tx_sync[1] : st_ff.rx_sync[1];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic frame_done;
        logic par_bad;
        logic err;
        logic start_m;
        logic sig_m;
        logic addr_m;
        logic take;
        logic popped;
        logic [DATA_W-1:0] fr;
        frame_done = 1'b0;
        par_bad = 1'b0;
        err = 1'b0;
        start_m = 1'b0;
        sig_m = 1'b0;
        addr_m = 1'b0;
        take = 1'b0;
        popped = 1'b0;
        fr = '0;
        push = 1'b0;
        push_word = '0;
        nxt_st = st_ff;
        nxt_st.evt = '0;
        nxt_st.rx_sync = {st_ff.rx_sync[0], i_rx_pin};
        nxt_st.tx_sync = {st_ff.tx_sync[0], i_tx_pin};
        nxt_st.on = i_rx_enable;
        buf_full = (st_ff.count == CNT_W'(BUF_DEPTH));

        // Hold commands, set wins over clear
        if (i_hold_clear_cmd)
            nxt_st.hold = 1'b0;
        if (i_hold_set_cmd)
            nxt_st.hold = 1'b1;

        // Pop the buffer head
        if (i_buf_pop && st_ff.count != '0)
        begin
            popped = 1'b1;
            nxt_st.rd_ptr = ptr_inc(st_ff.rd_ptr);
        end

        // Waiting frame moves in as soon as space exists
        if (st_ff.pend_valid && (!buf_full || popped))
        begin
            push = 1'b1;
            push_word = st_ff.pend;
            nxt_st.pend_valid = 1'b0;
        end

        // Receiver sequencing on slow-clock ticks
        if (!i_rx_enable)
            nxt_st.state = ST_IDLE;
        else if (i_lf_tick)
        begin
            nxt_st.line_prev = line_in;
            case (st_ff.state)
                ST_IDLE:
                    if (st_ff.line_prev && !line_in)
                    begin
                        nxt_st.state = ST_RECV;
                        nxt_st.cyc = POS_W'(1);
                        // A start sample due at cycle zero is this low level itself
                        if (samp_pos('0, i_baud_divisor) == '0)
                        begin
                            nxt_st.bit_idx = BIT_W'(1);
                            nxt_st.target = samp_pos(BIT_W'(1), i_baud_divisor);
                        end
                        else
                        begin
                            nxt_st.bit_idx = '0;
                            nxt_st.target = samp_pos('0, i_baud_divisor);
                        end
                        nxt_st.par_acc = i_cfg.parity_odd;
                        nxt_st.stop_bad = 1'b0;
                    end
                ST_RECV:
                begin
                    nxt_st.cyc = POS_W'(st_ff.cyc + 1'b1);
                    if (st_ff.cyc == st_ff.target)
                    begin
                        nxt_st.bit_idx = BIT_W'(st_ff.bit_idx + 1'b1);
                        nxt_st.target = samp_pos(BIT_W'(st_ff.bit_idx + 1'b1),
                                                 i_baud_divisor);
                        if (st_ff.bit_idx == '0)
                        begin
                            if (line_in)
                                nxt_st.state = ST_IDLE;
                        end
                        else if (st_ff.bit_idx <= data_end)
                        begin
                            nxt_st.shreg = {line_in, st_ff.shreg[DATA_W-1:1]};
                            nxt_st.par_acc = st_ff.par_acc ^ line_in;
                        end
                        else if (i_cfg.parity_en && st_ff.bit_idx == BIT_W'(data_end + 1'b1))
                            nxt_st.par_acc = st_ff.par_acc ^ line_in;
                        else
                        begin
                            if (!line_in)
                                nxt_st.stop_bad = 1'b1;
                            if (st_ff.bit_idx == last_idx)
                            begin
                                nxt_st.state = ST_IDLE;
                                frame_done = 1'b1;
                                par_bad = i_cfg.parity_en && st_ff.par_acc;
                                err = par_bad || nxt_st.stop_bad;
                            end
                        end
                    end
                end
                default:
                    nxt_st.state = ST_IDLE;
            endcase
        end

        // Completed frame: recognise, then load, hold back or drop
        if (frame_done)
        begin
            fr = i_cfg.nine_bits ? nxt_st.shreg : {1'b0, nxt_st.shreg[DATA_W-1:1]};
            start_m = !err && pat_eq(fr, i_start_match_pattern, i_cfg.nine_bits);
            sig_m = !err && pat_eq(fr, i_signal_match_pattern, i_cfg.nine_bits);
            addr_m = !err && i_cfg.multidrop_enable && i_cfg.nine_bits
                     && fr[DATA_W-1] == i_cfg.addr_bit_value;
            nxt_st.evt.start_match_flag = start_m;
            nxt_st.evt.signal_match_flag = sig_m;
            nxt_st.evt.addr_frame_flag = addr_m;
            if (start_m && i_cfg.start_frame_unhold)
                nxt_st.hold = 1'b0;
            // Hold sampled at this exact cycle decides loading
            take = !st_ff.hold || addr_m
                   || (start_m && i_cfg.start_frame_unhold);
            if (take)
            begin
                nxt_st.evt.parity_fault = par_bad;
                nxt_st.evt.frame_fault = nxt_st.stop_bad;
                if (!push && !buf_full || !push && popped)
                begin
                    push = 1'b1;
                    push_word = {par_bad, nxt_st.stop_bad, fr};
                end
                else
                begin
                    nxt_st.evt.rx_overrun_flag = nxt_st.pend_valid;
                    nxt_st.pend_valid = 1'b1;
                    nxt_st.pend = {par_bad, nxt_st.stop_bad, fr};
                end
            end
            else if (nxt_st.pend_valid)
                nxt_st.evt.rx_overrun_flag = 1'b1;
        end

        // Occupancy and status
        if (push)
            nxt_st.wr_ptr = ptr_inc(st_ff.wr_ptr);
        nxt_st.count = CNT_W'(st_ff.count + CNT_W'(push) - CNT_W'(popped));
        nxt_st.valid = (nxt_st.count != '0);
        nxt_st.head = (st_ff.count == '0 || (popped && st_ff.count == CNT_W'(1)))
                      ? push_word
                      : mem_ff[popped ? ptr_inc(st_ff.rd_ptr) : st_ff.rd_ptr];
    end

    always_comb
    begin
        // Last data bit, then parity if on, then one or two stop bits
        data_end = i_cfg.nine_bits ? BIT_W'(DATA_W) : BIT_W'(DATA_W - 1);
        last_idx = BIT_W'(data_end + BIT_W'(i_cfg.parity_en) + BIT_W'(1)
                   + BIT_W'(i_cfg.two_stop));
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            st_ff <= '0;
            st_ff.line_prev <= 1'b1;
            st_ff.rx_sync <= 2'h3;
            st_ff.tx_sync <= 2'h3;
        end
        else
            st_ff <= nxt_st;
        if (push)
            mem_ff[st_ff.wr_ptr] <= push_word;
    end

    assign o_receive_hold_flag = st_ff.hold;
    assign o_rx_valid_flag = st_ff.valid;
    assign o_rx_word = st_ff.head;
    assign o_evt = st_ff.evt;
    assign o_rx_on_status = st_ff.on;
endmodule

/* File: rx_frame_filter_asserts.sv */
// Port-level checker for the receive frame filter.
// Assumes one core clock and the synchronous active-low reset.
`timescale 1ns/1ps
module rx_frame_filter_asserts #(
    parameter int BUF_DEPTH = rxf_pkg::BUF_DEPTH_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_rx_enable,
    input wire rxf_pkg::rx_cfg_t i_cfg,
    input wire logic i_hold_set_cmd,
    input wire logic i_hold_clear_cmd,
    input wire logic i_buf_pop,
    input wire logic o_receive_hold_flag,
    input wire logic o_rx_valid_flag,
    input wire rxf_pkg::rx_word_t o_rx_word,
    input wire rxf_pkg::rx_evt_t o_evt
);
    import rxf_pkg::*;
    // ----------------------------
    // Hold, match and buffer rules
    // ----------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);
    property p_hold_set;
        i_hold_set_cmd |=> o_receive_hold_flag;
    endproperty
    a_hold_set: assert property (p_hold_set) else $error("hold not set");
    property p_hold_clr;
        i_hold_clear_cmd && !i_hold_set_cmd |=> !o_receive_hold_flag;
    endproperty
    a_hold_clr: assert property (p_hold_clr) else $error("hold not cleared");
    property p_hold_rise;
        $rose(o_receive_hold_flag) |-> $past(i_hold_set_cmd);
    endproperty
    a_hold_rise: assert property (p_hold_rise) else $error("hold rose alone");
    property p_held_fault;
        $past(o_receive_hold_flag) && o_receive_hold_flag |-> !o_evt.parity_fault
            && !o_evt.frame_fault;
    endproperty
    a_held_fault: assert property (p_held_fault) else $error("fault while held");
    property p_fault_match;
        o_evt.parity_fault || o_evt.frame_fault |-> !o_evt.start_match_flag
            && !o_evt.signal_match_flag && !o_evt.addr_frame_flag;
    endproperty
    a_fault_match: assert property (p_fault_match) else $error("bad frame matched");
    property p_off_match;
        !$past(i_rx_enable) && !$past(i_rx_enable, 2) |-> !o_evt.start_match_flag
            && !o_evt.signal_match_flag && !o_evt.addr_frame_flag;
    endproperty
    a_off_match: assert property (p_off_match) else $error("match while off");
    property p_unhold;
        o_evt.start_match_flag && $past(i_cfg.start_frame_unhold) |-> ##[0:1]
            (!o_receive_hold_flag && o_rx_valid_flag);
    endproperty
    a_unhold: assert property (p_unhold) else $error("start match kept hold");
    property p_addr;
        o_evt.addr_frame_flag |-> $past(i_cfg.multidrop_enable) ##[0:1] o_rx_valid_flag;
    endproperty
    a_addr: assert property (p_addr) else $error("address frame wrong");
    property p_word_stable;
        $past(o_rx_valid_flag) && !$past(i_buf_pop) && !$past(i_buf_pop, 2)
            |-> $stable(o_rx_word);
    endproperty
    a_word_stable: assert property (p_word_stable) else $error("head moved");
    property p_overrun;
        o_evt.rx_overrun_flag |-> $past(o_rx_valid_flag);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun when empty");
    c_start: cover property (o_evt.start_match_flag && !o_receive_hold_flag);
    c_addr: cover property (o_evt.addr_frame_flag);
    c_ovr: cover property (o_evt.rx_overrun_flag);
endmodule
bind rx_frame_filter rx_frame_filter_asserts #(.BUF_DEPTH(BUF_DEPTH)) u_chk (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_rx_enable(i_rx_enable),
    .i_cfg(i_cfg), .i_hold_set_cmd(i_hold_set_cmd), .i_hold_clear_cmd(i_hold_clear_cmd),
    .i_buf_pop(i_buf_pop), .o_receive_hold_flag(o_receive_hold_flag),
    .o_rx_valid_flag(o_rx_valid_flag), .o_rx_word(o_rx_word), .o_evt(o_evt)
);

/* File: rx_line_peer.sv */
// Remote serial transmitter model driving the line.
// Assumes the bench's slow tick; one bit lasts two ticks.
`timescale 1ns/1ps
module rx_line_peer (
    input wire logic i_core_clk,
    input wire logic i_lf_tick,
    output logic o_line
);
    // Idle line sits high
    initial o_line = 1'h1;
    // Bits LSB first from a tick, then six idle ticks
    task automatic send(input logic [11:0] bits, input int nb);
        for (int i = 0; i < 2 * nb + 6; i++)
        begin
            @(posedge i_core_clk iff i_lf_tick);
            #1 o_line = (i < 2 * nb) ? bits[i / 2] : 1'h1;
        end
    endtask
endmodule

/* File: tb_rx_frame_filter.sv */
// Self-checking bench for the receive frame filter.
// Assumes the line peer model and a slow tick every four clocks.
`timescale 1ns/1ps
module tb_rx_frame_filter;
    import rxf_pkg::*;
    logic clk = 1'h0, rst_n = 1'h0, tick = 1'h0, en = 1'h1, line;
    logic set_c = 1'h0, clr_c = 1'h0, pop = 1'h0, loop_path = 1'h0, hold, valid, on_st;
    logic [1:0] tcnt = 2'h0;
    logic [8:0] st_pat = 9'h15A, sg_pat = 9'h0C3;
    rx_cfg_t cfg = '0;
    rx_word_t word;
    rx_evt_t evt, seen = '0;
    int n_errors = 0, samples_checked = 0;
    rx_frame_filter #(.BUF_DEPTH(2)) dut_u (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_lf_tick(tick),
        .i_rx_pin(loop_path ? 1'h1 : line), .i_tx_pin(loop_path ? line : 1'h1),
        .i_rx_enable(en), .i_cfg(cfg), .i_baud_divisor(15'h0100),
        .i_start_match_pattern(st_pat), .i_signal_match_pattern(sg_pat),
        .i_hold_set_cmd(set_c), .i_hold_clear_cmd(clr_c), .i_buf_pop(pop),
        .o_receive_hold_flag(hold), .o_rx_valid_flag(valid), .o_rx_word(word),
        .o_evt(evt), .o_rx_on_status(on_st)
    );
    rx_line_peer peer_u (.i_core_clk(clk), .i_lf_tick(tick), .o_line(line));
    // Clock, slow tick and sticky event capture
    always #5 clk = ~clk;
    always @(posedge clk) #1 {tick, tcnt} = {tcnt == 2'h3, tcnt + 2'h1};
    always @(posedge clk) seen <= seen | evt;
    // -------
    // Helpers
    // -------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic sig);
        sig = 1'h1;
        cyc(1);
        sig = 1'h0;
        cyc(2);
    endtask
    // One frame; parity bit is even parity flipped by bp, s is the stop level
    task automatic rx(input logic [8:0] d, input logic bp, input logic s);
        logic p;
        p = (cfg.nine_bits ? ^d : ^d[7:0]) ^ bp;
        seen = '0;
        if (cfg.nine_bits)
            peer_u.send({s, p, d, 1'h0}, 12);
        else
            peer_u.send({s, s, p, d[7:0], 1'h0}, cfg.two_stop ? 12 : 11);
        cyc(2);
    endtask
    task automatic res(input logic v, input logic [10:0] w, input logic [5:0] e);
        chk(16'(valid), 16'(v));
        if (v)
            chk(16'(word), 16'(w));
        chk(16'(seen), 16'(e));
    endtask
    // ---------
    // Scenarios
    // ---------
    task automatic t_faults;
        rx(9'h0A5, 1'h0, 1'h1);
        res(1'h1, 11'h0A5, 6'h00);
        pulse(pop);
        chk(16'(valid), 16'h0000);
        rx(9'h033, 1'h1, 1'h1);
        res(1'h1, 11'h433, 6'h20);
        pulse(pop);
        rx(st_pat, 1'h0, 1'h0);
        res(1'h1, 11'h35A, 6'h10);
        pulse(pop);
        cfg.nine_bits = 1'h0;
        cfg.parity_odd = 1'h1;
        cfg.two_stop = 1'h1;
        rx(9'h0A5, 1'h1, 1'h1);
        res(1'h1, 11'h0A5, 6'h00);
        pulse(pop);
        rx(9'h0A5, 1'h0, 1'h1);
        res(1'h1, 11'h4A5, 6'h20);
        pulse(pop);
        cfg.nine_bits = 1'h1;
        cfg.parity_odd = 1'h0;
        cfg.two_stop = 1'h0;
        $display("faults done");
    endtask
    task automatic t_hold;
        pulse(set_c);
        chk(16'(hold), 16'h0001);
        rx(9'h011, 1'h0, 1'h1);
        res(1'h0, 11'h000, 6'h00);
        rx(9'h022, 1'h1, 1'h0);
        res(1'h0, 11'h000, 6'h00);
        pulse(clr_c);
        chk(16'(hold), 16'h0000);
        $display("hold done");
    endtask
    task automatic t_start;
        cfg.start_frame_unhold = 1'h1;
        pulse(set_c);
        rx(9'h0AA, 1'h0, 1'h1);
        res(1'h0, 11'h000, 6'h00);
        rx(st_pat, 1'h0, 1'h1);
        res(1'h1, 11'h15A, 6'h08);
        chk(16'(hold), 16'h0000);
        pulse(pop);
        cfg.start_frame_unhold = 1'h0;
        rx(st_pat, 1'h0, 1'h1);
        res(1'h1, 11'h15A, 6'h08);
        pulse(pop);
        rx(9'h05A, 1'h0, 1'h1);
        res(1'h1, 11'h05A, 6'h00);
        pulse(pop);
        cfg.nine_bits = 1'h0;
        rx(9'h05A, 1'h0, 1'h1);
        res(1'h1, 11'h05A, 6'h08);
        pulse(pop);
        cfg.nine_bits = 1'h1;
        $display("start done");
    endtask
    task automatic t_signal;
        rx(sg_pat, 1'h0, 1'h1);
        res(1'h1, 11'h0C3, 6'h04);
        pulse(pop);
        rx(sg_pat, 1'h1, 1'h1);
        res(1'h1, 11'h4C3, 6'h20);
        pulse(pop);
        en = 1'h0;
        rx(sg_pat, 1'h0, 1'h1);
        res(1'h0, 11'h000, 6'h00);
        chk(16'(on_st), 16'h0000);
        en = 1'h1;
        cyc(8);
        chk(16'(on_st), 16'h0001);
        $display("signal done");
    endtask
    task automatic t_addr;
        cfg.multidrop_enable = 1'h1;
        cfg.addr_bit_value = 1'h1;
        pulse(set_c);
        rx(9'h133, 1'h0, 1'h1);
        res(1'h1, 11'h133, 6'h02);
        pulse(pop);
        pulse(clr_c);
        rx(9'h033, 1'h0, 1'h1);
        res(1'h1, 11'h033, 6'h00);
        pulse(pop);
        pulse(set_c);
        cfg.multidrop_enable = 1'h0;
        rx(9'h133, 1'h0, 1'h1);
        res(1'h0, 11'h000, 6'h00);
        pulse(clr_c);
        $display("addr done");
    endtask
    task automatic t_overrun;
        for (int i = 1; i < 4; i++)
            rx(9'(i), 1'h0, 1'h1);
        res(1'h1, 11'h001, 6'h00);
        rx(9'h004, 1'h0, 1'h1);
        res(1'h1, 11'h001, 6'h01);
        pulse(set_c);
        pulse(pop);
        chk(16'(word), 16'h0002);
        pulse(pop);
        chk(16'(word), 16'h0004);
        pulse(pop);
        chk(16'(valid), 16'h0000);
        pulse(clr_c);
        $display("overrun done");
    endtask
    task automatic t_loop;
        loop_path = 1'h1;
        cfg.internal_loop = 1'h1;
        rx(9'h066, 1'h0, 1'h1);
        res(1'h1, 11'h066, 6'h00);
        pulse(pop);
        cfg.internal_loop = 1'h0;
        rx(9'h077, 1'h0, 1'h1);
        res(1'h0, 11'h000, 6'h00);
        loop_path = 1'h0;
        $display("loop done");
    endtask
    // Hang guard
    initial
    begin
        #200000;
        n_errors++;
        print_verdict();
    end
    // Main sequence
    initial
    begin
        cfg.nine_bits = 1'h1;
        cfg.parity_en = 1'h1;
        cyc(2);
        rst_n = 1'h1;
        cyc(20);
        t_faults();
        t_hold();
        t_start();
        t_signal();
        t_addr();
        t_overrun();
        t_loop();
        print_verdict();
    end
endmodule
